// *** common/rts_regs.vh ***
/*
 * Register offsets, field positions, reset values and timing counts for the
 * transmit serializer event block.
 * Assumes a byte-wide register port decoded by the surrounding host port.
 */
`ifndef RTS_REGS_VH
`define RTS_REGS_VH

// ****************************************************************
// Register offsets (register index on the byte port)
// ****************************************************************
`define RTS_OFF_MODE 8'h03
`define RTS_OFF_EVT_MASK 8'h0D
`define RTS_OFF_EVT_FLAGS 8'h0E
`define RTS_OFF_PAYLOAD 8'h0F
`define RTS_OFF_QUALIFIER 8'h10
`define RTS_OFF_SEQ_LO 8'h11
`define RTS_OFF_SEQ_HI 8'h18

// ****************************************************************
// Field positions
// ****************************************************************
`define RTS_EVT_UNDERFLOW 3
`define RTS_EVT_OVERFLOW 2
`define RTS_EVT_DONE 1
`define RTS_EVT_EMPTY 0
`define RTS_MODE_TX_BIT 7
`define RTS_MODE_RX_BIT 6
`define RTS_SEQ_HALF_BIT 0

// ****************************************************************
// Reset values
// ****************************************************************
`define RTS_RST_BYTE 8'h00
`define RTS_RST_SEQ 64'h0000_0000_0000_0000

// ****************************************************************
// Timing: chips per bit in full and split code mode
// ****************************************************************
`define RTS_CHIPS_FULL 7'h40
`define RTS_CHIPS_HALF 7'h20

`endif

// *** logic/rts_chip_gen.v ***
/*
 * Chip generator: walks the spreading sequence from bit 0 upward, one chip
 * per chip_en pulse, and flags the end of each data bit time.
 * Assumes chip_en is a one-cycle pulse from a divider outside the parent, which passes it through.
 */
`timescale 1ns/1ps

module rts_chip_gen
(
	input wire sys_clk,
	input wire nrst,
	input wire chip_en,
	input wire half_mode,
	input wire [63:0] seq,
	output reg chip_q,
	output reg bit_end_q
);

	reg [5:0] idx_q;
	wire [5:0] last;

	// Split mode uses only the low 32 chips per bit
	assign last = half_mode ? 6'h1F : 6'h3F;

	// ****************************************************************
	// Chip index walk
	// ****************************************************************
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			idx_q <= 6'h00;
			chip_q <= 1'b0;
			bit_end_q <= 1'b0;
		end
		else
		begin
			bit_end_q <= 1'b0;
			if (chip_en)
			begin
				chip_q <= seq[idx_q];
				// At or past the end, so a switch to split mode in mid bit
				// cannot run the index on and skip a bit end
				if (idx_q >= last)
				begin
					idx_q <= 6'h00;
					bit_end_q <= 1'b1;
				end
				else
					idx_q <= idx_q + 6'h01;
			end
		end
	end

endmodule // rts_chip_gen

// *** logic/rts_serializer.v ***
/*
 * Transmit serializer with event flags, masks and interrupt output.
 * Assumes a byte register port (addr, wr_en, rd_en, wdata) driven by the
 * host-side serial framing logic, synchronous to sys_clk.
 */
`timescale 1ns/1ps

`include "rts_regs.vh"

module rts_serializer
(
	input wire sys_clk,
	input wire nrst,
	input wire [7:0] addr,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] wdata,
	input wire chip_en,
	output reg [7:0] rdata_q,
	output reg irq_q,
	output reg air_chip_q,
	output reg tx_active_q
);

	reg [7:0] mode_q;
	reg [7:0] mask_q;
	reg [3:0] flags_q;
	reg [7:0] payload_q;
	reg [7:0] qual_q;
	reg pending_q;
	reg [63:0] seq_q;
	reg [7:0] sh_data_q;
	reg [7:0] sh_qual_q;
	reg busy_q;
	reg sent_one_q;
	reg cur_bit_q;
	reg cur_valid_q;
	reg [3:0] set_d;
	wire tx_mode;
	wire chip;
	wire bit_end;
	wire flag_rd;
	wire [3:0] flags_vis;

	// Byte index within the sequence register, used by read and write
	function [2:0] seq_idx;
		input [7:0] a;
		begin
			seq_idx = a[2:0] - 3'd1;
		end
	endfunction

	function in_seq;
		input [7:0] a;
		begin
			in_seq = (a >= `RTS_OFF_SEQ_LO) && (a <= `RTS_OFF_SEQ_HI);
		end
	endfunction

	assign tx_mode = mode_q[`RTS_MODE_TX_BIT] & ~mode_q[`RTS_MODE_RX_BIT];
	assign flag_rd = rd_en && (addr == `RTS_OFF_EVT_FLAGS);
	assign flags_vis = tx_mode ? flags_q : 4'h0;

	// ****************************************************************
	// Chip generator
	// ****************************************************************
	rts_chip_gen u_chip
	(
		.sys_clk(sys_clk),
		.nrst(nrst),
		.chip_en(chip_en),
		.half_mode(mode_q[`RTS_SEQ_HALF_BIT]),
		.seq(seq_q),
		.chip_q(chip),
		.bit_end_q(bit_end)
	);

	// ****************************************************************
	// Register writes
	// ****************************************************************
	// Flag register has no write path at all
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			mode_q <= `RTS_RST_BYTE;
			mask_q <= `RTS_RST_BYTE;
			payload_q <= `RTS_RST_BYTE;
			qual_q <= `RTS_RST_BYTE;
			seq_q <= `RTS_RST_SEQ;
		end
		else if (wr_en)
		begin
			case (addr)
				`RTS_OFF_MODE: mode_q <= wdata;
				`RTS_OFF_EVT_MASK: mask_q <= {4'h0, wdata[3:0]};
				`RTS_OFF_PAYLOAD: payload_q <= wdata;
				`RTS_OFF_QUALIFIER: qual_q <= wdata;
				default:
				begin
					if (in_seq(addr))
						seq_q[{seq_idx(addr), 3'b000} +: 8] <= wdata;
				end
			endcase
		end
	end

	// ****************************************************************
	// Event detection
	// ****************************************************************
	// Same priority as the shifter below; kept apart so the clocked
	// process holds only non-blocking updates
	always @*
	begin
		set_d = 4'h0;
		if (wr_en && addr == `RTS_OFF_PAYLOAD && pending_q)
			set_d[`RTS_EVT_OVERFLOW] = 1'b1;
		if (tx_mode && bit_end && sh_qual_q[7:1] == 7'h00)
		begin
			if (pending_q)
				set_d[`RTS_EVT_EMPTY] = 1'b1;
			else if (busy_q)
			begin
				set_d[`RTS_EVT_DONE] = 1'b1;
				if (sent_one_q)
					set_d[`RTS_EVT_UNDERFLOW] = 1'b1;
			end
		end
	end

	// ****************************************************************
	// Shifter
	// ****************************************************************
	// A payload write arms pending; the shifter takes it in transmit mode,
	// busy or idle, at the end of a bit time with no valid bits left.
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			pending_q <= 1'b0;
			sh_data_q <= 8'h00;
			sh_qual_q <= 8'h00;
			busy_q <= 1'b0;
			sent_one_q <= 1'b0;
			cur_bit_q <= 1'b0;
			cur_valid_q <= 1'b0;
			flags_q <= 4'h0;
		end
		else
		begin
			if (wr_en && addr == `RTS_OFF_PAYLOAD)
				pending_q <= 1'b1;
			if (tx_mode && bit_end)
			begin
				if (sh_qual_q[7:1] != 7'h00)
				begin
					// Next bit time, LSB first
					sh_data_q <= {1'b0, sh_data_q[7:1]};
					sh_qual_q <= {1'b0, sh_qual_q[7:1]};
					cur_bit_q <= sh_data_q[1];
					cur_valid_q <= sh_qual_q[1];
					sent_one_q <= 1'b1;
				end
				else if (pending_q)
				begin
					sh_data_q <= payload_q;
					sh_qual_q <= qual_q;
					cur_bit_q <= payload_q[0];
					cur_valid_q <= qual_q[0];
					busy_q <= 1'b1;
					if (busy_q)
						sent_one_q <= 1'b1;
					if (!(wr_en && addr == `RTS_OFF_PAYLOAD))
						pending_q <= 1'b0;
				end
				else if (busy_q)
				begin
					// Shifter ran dry: stop and drop the qualifier
					busy_q <= 1'b0;
					sh_qual_q <= 8'h00;
					cur_valid_q <= 1'b0;
				end
			end
			// Set beats read-clear so no event is lost; flags set regardless
			// of mask
			if (flag_rd)
				flags_q <= set_d;
			else
				flags_q <= flags_q | set_d;
		end
	end

	// ****************************************************************
	// Outputs: read data, interrupt, air chip
	// ****************************************************************
	always @(posedge sys_clk or negedge nrst)
	begin
		if (!nrst)
		begin
			rdata_q <= 8'h00;
			irq_q <= 1'b0;
			air_chip_q <= 1'b0;
			tx_active_q <= 1'b0;
		end
		else
		begin
			// Each event gated by its own enable, and all by transmit mode
			irq_q <= |(flags_vis & mask_q[3:0]);
			tx_active_q <= tx_mode & busy_q;
			// Invalid bit time sends preamble (plain chips), else XOR inverted data
			air_chip_q <= cur_valid_q ? (chip ^ ~cur_bit_q) : chip;
			if (rd_en)
			begin
				case (addr)
					`RTS_OFF_MODE: rdata_q <= mode_q;
					`RTS_OFF_EVT_MASK: rdata_q <= mask_q;
					`RTS_OFF_EVT_FLAGS: rdata_q <= {4'h0, flags_vis};
					`RTS_OFF_PAYLOAD: rdata_q <= payload_q;
					`RTS_OFF_QUALIFIER: rdata_q <= qual_q;
					default:
						rdata_q <= in_seq(addr) ?
							seq_q[{seq_idx(addr), 3'b000} +: 8] : 8'h00;
				endcase
			end
		end
	end

endmodule // rts_serializer

// *** verif/rts_chk_sva.sv ***
/* Port checker for the transmit serializer.
   Assumes a bind from the bench top and one clock domain. */
`timescale 1ns/1ps
module rts_chk
(
	input wire sys_clk,
	input wire nrst,
	input wire [7:0] addr,
	input wire wr_en,
	input wire rd_en,
	input wire [7:0] wdata,
	input wire chip_en,
	input wire [7:0] rdata_q,
	input wire irq_q,
	input wire air_chip_q,
	input wire tx_active_q
);
// ********
// Shadow of host writes
// ********
reg [7:0] mode_q;
reg [3:0] mask_q;
reg sent_q;
wire rd_fl = rd_en && addr == 8'h0E;
// Mirror mode and mask so reads can be judged without the bodies
always @(posedge sys_clk or negedge nrst)
	if (!nrst)
	begin
		mode_q <= 8'h00;
		mask_q <= 4'h0;
		sent_q <= 1'b0;
	end
	else
	begin
		if (wr_en && addr == 8'h03)
			mode_q <= wdata;
		if (wr_en && addr == 8'h0D)
			mask_q <= wdata[3:0];
		if (tx_active_q)
			sent_q <= 1'b1;
	end
default clocking @(posedge sys_clk); endclocking
default disable iff (!nrst);
property p_mask;
	rd_en && addr == 8'h0D |=> rdata_q[3:0] == mask_q;
endproperty
a_mask: assert property (p_mask) else $error("mask");
property p_off;
	rd_fl && !(mode_q[7] && !mode_q[6]) |=> rdata_q == 8'h00;
endproperty
a_off: assert property (p_off) else $error("off");
property p_rsv; rd_fl |=> rdata_q[7:4] == 4'h0; endproperty
a_rsv: assert property (p_rsv) else $error("rsv");
property p_wrh; wr_en |=> $stable(rdata_q); endproperty
a_wrh: assert property (p_wrh) else $error("wrh");
property p_und; rd_fl ##1 rdata_q[3] |-> sent_q; endproperty
a_und: assert property (p_und) else $error("und");
property p_cause; $rose(irq_q) |-> $past(mask_q) != 4'h0; endproperty
a_cause: assert property (p_cause) else $error("cause");
property p_nomask; mask_q == 4'h0 [*3] |-> !irq_q; endproperty
a_nomask: assert property (p_nomask) else $error("nomask");
property p_clr; $fell(irq_q) |-> $past(rd_en || wr_en, 2); endproperty
a_clr: assert property (p_clr) else $error("clr");
cover property ($rose(irq_q));
cover property ($rose(tx_active_q));
cover property (rd_fl ##1 rdata_q[0]);
endmodule // rts_chk

// *** verif/rts_host_model.sv ***
/* Host side of the byte register port.
   Assumes the bench calls wr and rd; requests change on falling edges. */
`timescale 1ns/1ps
module rts_host_model
(
	input wire sys_clk,
	input wire [7:0] rdata_q,
	output reg [7:0] addr = 8'h00,
	output reg wr_en = 1'b0,
	output reg rd_en = 1'b0,
	output reg [7:0] wdata = 8'h00
);
// ********
// Port cycles
// ********
// One-cycle write; data inverted on release so stale data never matches
task wr(input [7:0] a, input [7:0] d);
begin
	@(negedge sys_clk);
	addr = a;
	wdata = d;
	wr_en = 1'b1;
	@(negedge sys_clk);
	wr_en = 1'b0;
	wdata = ~d;
end
endtask
// Read data is taken after the edge that sampled the strobe
task rd(input [7:0] a, output [7:0] d);
begin
	@(negedge sys_clk);
	addr = a;
	rd_en = 1'b1;
	@(negedge sys_clk);
	rd_en = 1'b0;
	d = rdata_q;
end
endtask
endmodule // rts_host_model

// *** verif/tb_radio_tx_serializer_events.sv ***
/* Bench for the transmit serializer events block.
   Assumes the checker and host model compile first. */
`timescale 1ns/1ps
module tb_radio_tx_serializer_events;
reg sys_clk = 1'b0;
reg nrst = 1'b0;
reg chip_en = 1'b0;
wire [7:0] addr, wdata, rdata_q;
wire wr_en, rd_en, irq_q, air_chip_q, tx_active_q;
integer miscompares = 0;
integer n_checks = 0;
integer cyc = 0;
integer i;
integer n;
reg [7:0] d;
rts_serializer i_rts_serializer (.sys_clk(sys_clk), .nrst(nrst),
	.addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
	.chip_en(chip_en), .rdata_q(rdata_q), .irq_q(irq_q),
	.air_chip_q(air_chip_q), .tx_active_q(tx_active_q));
rts_host_model i_rts_host_model (.sys_clk(sys_clk), .rdata_q(rdata_q),
	.addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata));
// ********
// Clock, limit and reporting
// ********
initial
	forever #20 sys_clk = ~sys_clk;
// A hang counts as a mismatch
always @(posedge sys_clk)
begin
	cyc = cyc + 1;
	if (cyc == 20000)
	begin
		miscompares = miscompares + 1;
		wrap_up;
	end
end
task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
begin
	n_checks = n_checks + 1;
	if (g !== e)
	begin
		miscompares = miscompares + 1;
		$display("unexpected %0s exp %h got %h", nm, e, g);
	end
end
endtask
task wrap_up;
begin
	if (miscompares == 0 && n_checks > 0)
		$display("Finished cleanly");
	else
		$display("Finished with errors");
	$finish;
end
endtask
// Bounded wait for the shifter; n counts the cycles waited
task wait_act(input v);
begin
	n = 0;
	while (tx_active_q !== v && n < 600)
	begin
		@(negedge sys_clk);
		n = n + 1;
	end
end
endtask
// ********
// Scenarios
// ********
task t_regs;
begin
	for (i = 13; i < 17; i = i + 1)
	begin
		i_rts_host_model.rd(i[7:0], d);
		chk("reset", 8'h00, d);
	end
	i_rts_host_model.wr(8'h0D, 8'h0A);
	i_rts_host_model.rd(8'h0D, d);
	chk("mask", 8'h0A, d);
	i_rts_host_model.wr(8'h0E, 8'h0F);
	i_rts_host_model.rd(8'h0E, d);
	chk("ro", 8'h00, d);
	i_rts_host_model.wr(8'h0D, 8'h00);
end
endtask
// All-ones code in both halves makes each chip equal to its data bit
task t_tx;
begin
	for (i = 17; i < 25; i = i + 1)
		i_rts_host_model.wr(i[7:0], 8'hFF);
	i_rts_host_model.wr(8'h03, 8'h81);
	i_rts_host_model.wr(8'h10, 8'hFF);
	i_rts_host_model.wr(8'h0F, 8'hA5);
	wait_act(1'b1);
	repeat (16) @(negedge sys_clk);
	for (i = 0; i < 8; i = i + 1)
	begin
		d = 8'hA5 >> i;
		chk("chip", d & 8'h01, {7'h00, air_chip_q});
		repeat (32) @(negedge sys_clk);
	end
	wait_act(1'b0);
	i_rts_host_model.rd(8'h0E, d);
	chk("flags", 8'h0B, d);
	chk("irq", 8'h00, {7'h00, irq_q});
	// Half byte only after the empty event was seen
	i_rts_host_model.wr(8'h10, 8'h0F);
	i_rts_host_model.wr(8'h0F, 8'h3C);
	wait_act(1'b1);
	wait_act(1'b0);
	d = (n + 16) / 32;
	chk("bits", 8'h04, d);
	i_rts_host_model.rd(8'h0E, d);
	chk("flags2", 8'h0B, d);
end
endtask
// Second byte lands before the first has moved
task t_ovf;
begin
	// Transmit off, so no bit end can move the first byte between writes
	i_rts_host_model.wr(8'h03, 8'h01);
	i_rts_host_model.wr(8'h0D, 8'h04);
	i_rts_host_model.wr(8'h0F, 8'h11);
	i_rts_host_model.wr(8'h0F, 8'h22);
	repeat (2) @(negedge sys_clk);
	chk("irq_off", 8'h00, {7'h00, irq_q});
	i_rts_host_model.wr(8'h03, 8'h81);
	repeat (3) @(negedge sys_clk);
	chk("irq_ovf", 8'h01, {7'h00, irq_q});
	i_rts_host_model.rd(8'h0E, d);
	chk("ovf", 8'h04, d & 8'h04);
	repeat (2) @(negedge sys_clk);
	chk("irq_clr", 8'h00, {7'h00, irq_q});
	wait_act(1'b1);
	wait_act(1'b0);
	// Flags now pending, but hidden once transmit mode is left
	i_rts_host_model.wr(8'h03, 8'h00);
	i_rts_host_model.rd(8'h0E, d);
	chk("off", 8'h00, d);
end
endtask
initial
begin
	repeat (16) @(negedge sys_clk);
	nrst = 1'b1;
	chip_en = 1'b1;
	t_regs;
	t_tx;
	t_ovf;
	wrap_up;
end
endmodule // tb_radio_tx_serializer_events
bind rts_serializer rts_chk i_rts_chk (.sys_clk(sys_clk), .nrst(nrst),
	.addr(addr), .wr_en(wr_en), .rd_en(rd_en), .wdata(wdata),
	.chip_en(chip_en), .rdata_q(rdata_q), .irq_q(irq_q),
	.air_chip_q(air_chip_q), .tx_active_q(tx_active_q));
